// File: hw/emc_defs.svh
// Register offsets, field positions, reset values and timing counts
`ifndef EMC_DEFS_SVH
`define EMC_DEFS_SVH

// ------------------------------------------------------------
// Register byte offsets
// ------------------------------------------------------------
`define EMC_OFS_MODE     12'h000
`define EMC_OFS_RWAIT    12'h004
`define EMC_OFS_PDOWN    12'h008
`define EMC_OFS_CLKDIV   12'h00c
`define EMC_OFS_CLKEN    12'h010
`define EMC_OFS_MTYPE    12'h014
`define EMC_OFS_WWAIT    12'h018
`define EMC_OFS_STATUS   12'h01c

// ------------------------------------------------------------
// Field positions and reset values
// ------------------------------------------------------------
`define EMC_PDOWN_BIT    0
`define EMC_PDOWN_POL    1
`define EMC_RST_MODE     1'b1
`define EMC_RST_WAIT     3'h0
`define EMC_RST_DIV      2'h0
`define EMC_RST_CLKEN    1'b0
`define EMC_RST_MTYPE    1'b0
`define EMC_RST_PDOWN    2'h0

// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
`define EMC_WAKE_MEMCLKS 2

`endif

// File: hw/emc_pkg.sv
// Types shared by the external memory controller
package emc_pkg;

  typedef enum logic {
    EMC_MEM_SYNC  = 1'b0,
    EMC_MEM_ASYNC = 1'b1
  } emc_mem_type_t;

  typedef enum logic {
    EMC_MODE_CUSTOM  = 1'b0,
    EMC_MODE_BUILTIN = 1'b1
  } emc_mode_t;

  // Strobes towards the control port, active low except clock and sleep
  typedef struct packed {
    logic ext_mem_clk;
    logic ext_chip_enable_n;
    logic ext_output_enable_n;
    logic ext_write_enable_n;
    logic ext_addr_strobe_n;
    logic ext_sleep_line;
  } emc_strobe_t;

  // Transfer request from the peripheral hub
  typedef struct packed {
    logic req;
    logic write;
  } emc_hub_req_t;

endpackage : emc_pkg

// File: hw/emc_ext_mem_ctrl.sv
// External memory controller: strobes, memory clock, wait states, sleep line
//
// Notes on behaviour
// R01 - Memory clock is bus clock divided 1-4; ratios 2 and 3 leave it stuck high
// R02 - No address or data path, strobes only
// R03 - Supports sync, async, pseudo SRAM, NOR flash
// R04 - External address up to 24 bits
// R05 - External data 8 or 16 bits
// R06 - Address ports mapped by port role select
// R07 - Data ports mapped by port role select
// R08 - Software sets control port bypass bit
// R09 - Strobes use three to six control pins
// R10 - Mode picks builtin or custom interface
// R11 - Memory type picks sync or async strobes
// R12 - Separate read and write extra waits
// R13 - Up to seven extra waits added
// R14 - Base waits 2N-1 read, 2N write
// R15 - Software keeps memory clock under 33 MHz
// R16 - Clock enable switches whole block off; the APB registers and the strobe output flops stay live
// R17 - Settings kept through chip sleep
// R18 - Sleep asserted after current transfer ends
// R19 - Wake needs two memory clocks before access
// R20 - Sleep line polarity programmable
// R21 - Runs on the bus clock
// R22 - Peripherals behave as async memory
// R23 - Async strobes held for all waits
`timescale 1ns/1ns

`include "emc_defs.svh"

module emc_ext_mem_ctrl
  import emc_pkg::*;
#(
  parameter int unsigned WAIT_W = 3
) (
  input  wire logic          pclk,
  input  wire logic          presetn,
  input  wire logic          clk_en,
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [11:0]   paddr,
  input  wire logic [31:0]   pwdata,
  output logic      [31:0]   prdata,
  output logic               pready,
  output logic               pslverr,
  input  emc_hub_req_t       hub_req,
  output logic               hub_ready,
  output emc_strobe_t        strobes,
  output logic               custom_mode,
  output logic               busy
);

  // ------------------------------------------------------------
  // Configuration registers
  // ------------------------------------------------------------
  // No address or data word passes here; the hub drives the ports itself. R02
  // Limits of the port wiring the strobes must serve
  localparam int unsigned ADDR_BITS_MAX = 24; // R04
  localparam int unsigned ADDR_PORTS    = 3; // R06
  localparam int unsigned DATA_PORTS    = 2; // R07
  localparam int unsigned DATA_BITS_MAX = 8 * DATA_PORTS; // R05
  logic              mode_q;
  logic [WAIT_W-1:0] rwait_q;
  logic [WAIT_W-1:0] wwait_q;
  logic [1:0]        pdown_q;
  logic [1:0]        div_q;
  logic              clken_q;
  logic              mtype_q;

  // Block gate: bus side stays live so software can reenable it
  logic run;
  assign run = clk_en && clken_q; // R16

  function automatic logic hit(input logic [11:0] a, input logic [11:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  logic wr_en;
  assign wr_en = psel && penable && pwrite;

  // Plain flops with no sleep clear, so settings survive chip sleep R17
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q  <= `EMC_RST_MODE;
      rwait_q <= '0;
      wwait_q <= '0;
      pdown_q <= `EMC_RST_PDOWN;
      div_q   <= `EMC_RST_DIV;
      clken_q <= `EMC_RST_CLKEN;
      mtype_q <= `EMC_RST_MTYPE;
    end else if (clk_en && wr_en) begin
      if (hit(paddr, `EMC_OFS_MODE))   mode_q  <= pwdata[0]; // R10
      if (hit(paddr, `EMC_OFS_RWAIT))  rwait_q <= pwdata[WAIT_W-1:0]; // R12
      if (hit(paddr, `EMC_OFS_WWAIT))  wwait_q <= pwdata[WAIT_W-1:0]; // R12
      if (hit(paddr, `EMC_OFS_PDOWN))  pdown_q <= pwdata[1:0]; // R20
      if (hit(paddr, `EMC_OFS_CLKDIV)) div_q   <= pwdata[1:0]; // R01
      if (hit(paddr, `EMC_OFS_CLKEN))  clken_q <= pwdata[0];
      if (hit(paddr, `EMC_OFS_MTYPE))  mtype_q <= pwdata[0]; // R11
    end
  end

  // ------------------------------------------------------------
  // APB read side
  // ------------------------------------------------------------
  logic mapped;
  logic sleep_q;
  logic waking;
  assign mapped = (paddr[11:5] == 7'h00) && (paddr[1:0] == 2'h0);
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !mapped;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (clk_en && psel && !penable && !pwrite) begin
      prdata <= 32'h0000_0000;
      case (paddr)
        `EMC_OFS_MODE:   prdata[0]          <= mode_q;
        `EMC_OFS_RWAIT:  prdata[WAIT_W-1:0] <= rwait_q;
        `EMC_OFS_WWAIT:  prdata[WAIT_W-1:0] <= wwait_q;
        `EMC_OFS_PDOWN:  prdata[1:0]        <= pdown_q;
        `EMC_OFS_CLKDIV: prdata[1:0]        <= div_q;
        `EMC_OFS_CLKEN:  prdata[0]          <= clken_q;
        `EMC_OFS_MTYPE:  prdata[0]          <= mtype_q;
        `EMC_OFS_STATUS: prdata[2:0]        <= {waking, sleep_q, busy};
        default:         prdata             <= 32'h0000_0000;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Memory clock divider
  // ------------------------------------------------------------
  logic [1:0] div_cnt_q;
  logic       tick;
  logic       mclk_q;
  assign tick = run && (div_cnt_q == div_q); // R01

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_cnt_q <= 2'h0;
    end else if (run) begin
      div_cnt_q <= tick ? 2'h0 : div_cnt_q + 2'h1; // R21
    end
  end

  // Divide by one toggles every edge; ratios two and three leave the clock stuck high
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mclk_q <= 1'b0;
    end else if (run) begin
      if (div_q == 2'h0)
        mclk_q <= ~mclk_q;
      else if (div_cnt_q == 2'h0)
        mclk_q <= 1'b1;
      else if (div_cnt_q == {1'b0, div_q[1]} + 2'h1 || div_cnt_q == div_q)
        mclk_q <= (div_cnt_q == div_q) ? mclk_q : 1'b0;
    end
  end

  // ------------------------------------------------------------
  // Transfer sequencer
  // ------------------------------------------------------------
  typedef enum logic [1:0] { ST_IDLE, ST_ACCESS, ST_DONE } st_t;
  st_t        st_q;
  logic [4:0] wcnt_q;
  logic       wr_q;
  logic [4:0] total;
  logic [3:0] base_n;
  logic       can_start;

  // Reads 2N-1, writes 2N, plus the programmed extra R14
  assign base_n = {1'b0, div_q, 1'b0} + 4'h2;
  always_comb begin
    if (hub_req.write)
      total = {1'b0, base_n} + {2'b00, wwait_q}; // R13
    else
      total = {1'b0, base_n} - 5'h1 + {2'b00, rwait_q}; // R13
  end

  assign can_start = run && hub_req.req && !sleep_q && !waking; // R19

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q   <= ST_IDLE;
      wcnt_q <= 5'h00;
      wr_q   <= 1'b0;
    end else if (run) begin
      case (st_q)
        ST_IDLE: begin
          if (can_start) begin
            st_q   <= ST_ACCESS;
            wcnt_q <= total;
            wr_q   <= hub_req.write;
          end
        end
        ST_ACCESS: begin
          if (wcnt_q <= 5'h1)
            st_q <= ST_DONE; // R23
          else
            wcnt_q <= wcnt_q - 5'h1;
        end
        ST_DONE: st_q <= ST_IDLE;
        default: st_q <= ST_IDLE;
      endcase
    end
  end

  assign busy      = (st_q != ST_IDLE);
  assign hub_ready = run && (st_q == ST_DONE);

  // ------------------------------------------------------------
  // Sleep line and wake delay
  // ------------------------------------------------------------
  logic [1:0] wake_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sleep_q <= 1'b0;
      wake_q  <= 2'h0;
    end else if (run) begin
      if (pdown_q[`EMC_PDOWN_BIT] && !busy && !can_start)
        sleep_q <= 1'b1; // R18
      else if (!pdown_q[`EMC_PDOWN_BIT] && sleep_q) begin
        sleep_q <= 1'b0;
        wake_q  <= 2'(`EMC_WAKE_MEMCLKS); // R19
      end else if (wake_q != 2'h0 && tick)
        wake_q <= wake_q - 2'h1; // R19
    end
  end
  assign waking = (wake_q != 2'h0);

  // ------------------------------------------------------------
  // Strobe outputs
  // ------------------------------------------------------------
  // Address strobe only in sync mode; custom mode leaves the enable and address strobes idle
  logic act;
  logic sync_m;
  assign act    = (st_q == ST_ACCESS) && mode_q;
  // Pseudo SRAM and NOR flash ride on the async strobe set R03
  assign sync_m = (mtype_q == EMC_MEM_SYNC);
  assign custom_mode = !mode_q; // R10

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strobes <= '{1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
    end else if (clk_en) begin
      strobes.ext_mem_clk         <= mclk_q && sync_m && run; // R09
      strobes.ext_chip_enable_n   <= !act; // R23
      strobes.ext_output_enable_n <= !(act && !wr_q); // R23
      strobes.ext_write_enable_n  <= !(act && wr_q); // R23
      strobes.ext_addr_strobe_n   <= !(act && sync_m && wcnt_q == total); // R11
      strobes.ext_sleep_line      <= sleep_q ^ pdown_q[`EMC_PDOWN_POL]; // R20
    end
  end

endmodule : emc_ext_mem_ctrl

// File: bench/emc_ext_mem_ctrl_sva.sv
// Port checker for the external memory controller
`timescale 1ns/1ns
module emc_sva
  import emc_pkg::*;
(
  input wire logic   pclk,
  input wire logic   presetn,
  input wire logic   clk_en,
  input wire logic   psel,
  input wire logic   penable,
  input wire logic   pready,
  input emc_hub_req_t hub_req,
  input wire logic   hub_ready,
  input emc_strobe_t strobes,
  input wire logic   busy
);
  // --------
  // Relations
  // --------
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_zero_wait: assert property (psel && penable |-> pready)
    else $error("pready low in access");
  a_gate_hold: assert property (!clk_en |=> $stable(strobes))
    else $error("strobes moved while gated");
  a_one_pulse: assert property (hub_ready |=> !hub_ready)
    else $error("hub_ready longer than one cycle");
  a_ready_req: assert property (hub_ready |-> hub_req.req)
    else $error("hub_ready without request");
  a_strobe_off: assert property (hub_ready |=> strobes.ext_chip_enable_n
    && strobes.ext_output_enable_n && strobes.ext_write_enable_n)
    else $error("strobes still low after completion");
  a_oe_we_excl: assert property (strobes.ext_output_enable_n
    || strobes.ext_write_enable_n)
    else $error("read and write strobes together");
  a_sleep_idle: assert property ($changed(strobes.ext_sleep_line) |-> !$past(busy))
    else $error("sleep line moved during a transfer");
  a_done_bound: assert property ($rose(busy) |-> ##[1:20] hub_ready)
    else $error("transfer too long");
  a_no_early: assert property ($rose(busy) |-> !hub_ready)
    else $error("transfer ended at once");
endmodule : emc_sva

// File: bench/emc_mem_model.sv
// Behavioural external SRAM watching the strobes
`timescale 1ns/1ns
module emc_mem_model
  import emc_pkg::*;
(
  input wire logic   pclk,
  input emc_strobe_t strobes,
  input wire logic   sleep_on,
  output int         ce_len,
  output int         bad
);
  int run = 0;
  int awake = 9;
  // --------
  // Watch
  // --------
  // Plain async part, the way a mapped peripheral must look
  initial ce_len = 0;
  // Strobes arrive as if the control port bypass were already set
  initial bad = 0;
  always @(posedge pclk) begin
    if (!strobes.ext_chip_enable_n) run <= run + 1;
    else if (run != 0) ce_len <= run;
    if (strobes.ext_chip_enable_n) run <= 0;
    if (strobes.ext_sleep_line == sleep_on) awake <= 0;
    else if (awake < 9) awake <= awake + 1;
    // Counts bus clocks, an upper bound on memory clocks
    if (!strobes.ext_chip_enable_n && awake < 2) bad <= bad + 1;
  end
endmodule : emc_mem_model

// File: bench/emc_ext_mem_ctrl_tb.sv
// Self-checking bench for the external memory controller
`timescale 1ns/1ns
`include "emc_defs.svh"
`define CHK(n, e, s) begin compares++; if ((s) !== (e)) begin err_total++; \
  $display("[FAIL] %s exp %0h got %0h", n, e, s); end end
module emc_ext_mem_ctrl_tb
  import emc_pkg::*;
;
  logic         pclk = 0, presetn = 0, clk_en = 1, psel = 0, penable = 0;
  logic         pwrite = 0, pready, pslverr, se, hub_ready, custom_mode, busy;
  logic         sleep_on = 1;
  logic [11:0]  paddr = 12'h000;
  logic [31:0]  pwdata = 32'h0, prdata, r;
  emc_hub_req_t hub_req = '0;
  emc_strobe_t  strobes;
  int           err_total = 0, compares = 0, ce_len, bad;
  always #50 pclk = ~pclk;
  emc_ext_mem_ctrl dut_u (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .hub_req(hub_req), .hub_ready(hub_ready),
    .strobes(strobes), .custom_mode(custom_mode), .busy(busy));
  emc_mem_model mem_u (.pclk(pclk), .strobes(strobes), .sleep_on(sleep_on),
    .ce_len(ce_len), .bad(bad));
  // --------
  // Tasks
  // --------
  task automatic stop_test;
    if (err_total == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : stop_test
  task automatic hang;
    err_total++;
    stop_test();
  endtask : hang
  task automatic tick(input int k);
    repeat (k) @(posedge pclk);
  endtask : tick
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    for (n = 0; n < 20 && pready !== 1'b1; n++) @(posedge pclk);
    r = prdata;
    se = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n == 20) hang();
    @(posedge pclk);
  endtask : apb
  task automatic xfer(input logic w, output int n);
    hub_req <= '{1'b1, w};
    n = 0;
    // Look at the ready pulse mid-cycle, where it has settled
    do begin
      @(posedge pclk);
      n++;
      @(negedge pclk);
    end while (n < 60 && hub_ready !== 1'b1);
    @(posedge pclk);
    hub_req <= '0;
    if (n == 60) hang();
    @(posedge pclk);
  endtask : xfer
  task automatic t_reset;
    for (int k = 0; k < 8; k++) begin
      apb(1'b0, 12'(k * 4), 32'h0);
      `CHK("reset_val", 32'(k == 0), r)
    end
    apb(1'b1, `EMC_OFS_RWAIT, 32'h7);
    apb(1'b0, `EMC_OFS_RWAIT, 32'h0);
    `CHK("rwait", 32'h7, r)
    apb(1'b1, `EMC_OFS_MODE, 32'h0);
    `CHK("custom", 1'b1, custom_mode)
    apb(1'b1, `EMC_OFS_MODE, 32'h1);
    `CHK("builtin", 1'b0, custom_mode)
    apb(1'b0, 12'h020, 32'h0);
    `CHK("unmapped", 33'h0, {se, r} ^ 33'h100000000)
  endtask : t_reset
  task automatic t_gate;
    for (int i = 0; i < 2; i++) begin
      apb(1'b1, `EMC_OFS_CLKEN, 32'(i));
      clk_en <= (i == 0);
      hub_req <= '{1'b1, 1'b0};
      repeat (30) begin
        @(posedge pclk);
        `CHK("gated", 1'b0, hub_ready)
      end
      hub_req <= '0;
      clk_en <= 1'b1;
      tick(1);
    end
  endtask : t_gate
  task automatic t_wait;
    int n;
    apb(1'b1, `EMC_OFS_MTYPE, 32'h1);
    for (int k = 0; k < 8; k++) begin
      apb(1'b1, `EMC_OFS_CLKDIV, 32'(k / 2));
      apb(1'b1, `EMC_OFS_RWAIT, 32'(k % 2 * 7));
      apb(1'b1, `EMC_OFS_WWAIT, 32'(k % 2 * 7));
      xfer(1'b0, n);
      `CHK("rd_cycles", k / 2 * 2 + 2 + k % 2 * 7, n)
      tick(1);
      `CHK("ce_width", k / 2 * 2 + 1 + k % 2 * 7, ce_len)
      xfer(1'b1, n);
      `CHK("wr_cycles", k / 2 * 2 + 3 + k % 2 * 7, n)
    end
  endtask : t_wait
  task automatic t_sleep;
    int n;
    apb(1'b1, `EMC_OFS_PDOWN, 32'h1);
    tick(2);
    `CHK("asleep", 1'b1, strobes.ext_sleep_line)
    sleep_on <= 1'b0;
    apb(1'b1, `EMC_OFS_PDOWN, 32'h3);
    tick(2);
    `CHK("inverted", 1'b0, strobes.ext_sleep_line)
    apb(1'b1, `EMC_OFS_PDOWN, 32'h2);
    xfer(1'b0, n);
    `CHK("wake_delay", 1'b1, n > 16)
    `CHK("wake_gap", 0, bad)
    fork
      xfer(1'b0, n);
      begin
        tick(2);
        apb(1'b1, `EMC_OFS_PDOWN, 32'h3);
        `CHK("held_off", 1'b1, strobes.ext_sleep_line)
      end
    join
    tick(2);
    `CHK("late_sleep", 1'b0, strobes.ext_sleep_line)
  endtask : t_sleep
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_gate();
    t_wait();
    t_sleep();
    stop_test();
  end
endmodule : emc_ext_mem_ctrl_tb
bind emc_ext_mem_ctrl emc_sva chk_u (.pclk(pclk), .presetn(presetn), .clk_en(clk_en),
  .psel(psel), .penable(penable), .pready(pready), .hub_req(hub_req),
  .hub_ready(hub_ready), .strobes(strobes), .busy(busy));
